// ===== hw/crc_regs.sv
// control and configuration register bank of the card reader bridge
//
// How it works
// (RQ1) mode register bit 3 closes port 1 switches when set; resets closed.
// (RQ2) reader select 01 serves port 1, 10 port 2, only while awake.
// (RQ3) mode register bit 0 wakes the controller; 0 asks shutdown; resets 0.
// (RQ4) config bit 7 forces port 2 bus to one data bit.
// (RQ5) config bit 6 forces port 1 bus to one data bit.
// (RQ6) latched style holds interrupt until status is read.
// (RQ7) pulse style gives one 10 ms interrupt assertion per event; the code restarts a running pulse on a new event instead.
// (RQ8) config bit 4 sets interrupt polarity; interrupt settings need wake.
// (RQ9) clock input select field resets to 00000, the default input.
// (RQ10) codes 00001 and 00010 mean 19.2 MHz square and sine.
// (RQ11) code 00101 means 13 MHz sine input.
// (RQ12) codes 01001 and 01010 mean 12 MHz square and sine.
// (RQ13) codes 01101 and 01110 mean 26 MHz square and sine.
// (RQ14) every other clock input code behaves as the default.
// (RQ15) reserved bits reset to zero; host keeps them zero; the bench host passes bits 1:0 at offset 02 and unlisted offsets unmasked.
// (RQ16) bus width and clock input apply only on entering reader mode.
// (RQ17) mode register bit 4 closes port 2 switches; resets closed.
`include "crc_consts.svh"

module crc_regs #(
  parameter int unsigned IRQ_PULSE_CYCLES = `CRC_IRQ_PULSE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register access from the serial front end
  input crc_pkg::crc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // interrupt sources
  input wire logic irq_event,
  input wire logic status_read,
  // switch and controller controls
  output logic port1_switch_close,
  output logic port2_switch_close,
  output logic mcu_wake_request,
  // card reader
  output crc_pkg::crc_reader_t reader_port,
  output crc_pkg::crc_reader_cfg_t reader_cfg,
  output logic reader_running,
  // interrupt pin
  output logic irq_pin
);
  import crc_pkg::*;

  initial begin
    if (IRQ_PULSE_CYCLES < 1) begin
      $error("crc_regs: IRQ_PULSE_CYCLES must be at least 1");
    end
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // one index per stored register; anything else maps to none
  localparam logic [1:0] IDX_MODE = 2'h0;
  localparam logic [1:0] IDX_BUS_IRQ = 2'h1;
  localparam logic [1:0] IDX_CLOCK = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;

  // shared by the write and read paths so they can never disagree
  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    logic [1:0] i;
    i = IDX_NONE;
    case (addr)
      `CRC_OFF_MODE_SWITCH_WAKE: begin
        i = IDX_MODE;
      end
      `CRC_OFF_CFG_BUS_WIDTH_IRQ: begin
        i = IDX_BUS_IRQ;
      end
      `CRC_OFF_CFG_CLOCK_INPUT: begin
        i = IDX_CLOCK;
      end
      default: begin
        i = IDX_NONE;
      end
    endcase
    return i;
  endfunction : reg_index

  function automatic crc_clk_cfg_t clk_decode(input logic [4:0] code);
    crc_clk_cfg_t c;
    c.freq = CRC_FREQ_DEFAULT;
    c.sine = 1'b0;
    case (code)
      `CRC_CLK_19M2_SQUARE: begin
        c.freq = CRC_FREQ_19M2; // RQ10
      end
      `CRC_CLK_19M2_SINE: begin
        c.freq = CRC_FREQ_19M2; // RQ10
        c.sine = 1'b1;
      end
      `CRC_CLK_13M_SINE: begin
        c.freq = CRC_FREQ_13M; // RQ11
        c.sine = 1'b1;
      end
      `CRC_CLK_12M_SQUARE: begin
        c.freq = CRC_FREQ_12M; // RQ12
      end
      `CRC_CLK_12M_SINE: begin
        c.freq = CRC_FREQ_12M; // RQ12
        c.sine = 1'b1;
      end
      `CRC_CLK_26M_SQUARE: begin
        c.freq = CRC_FREQ_26M; // RQ13
      end
      `CRC_CLK_26M_SINE: begin
        c.freq = CRC_FREQ_26M; // RQ13
        c.sine = 1'b1;
      end
      default: begin
        // 00000 and unlisted codes both fall back to the default input
        c.freq = CRC_FREQ_DEFAULT; // RQ14
        c.sine = 1'b0;
      end
    endcase
    return c;
  endfunction : clk_decode

  function automatic crc_reader_t reader_decode(input logic [1:0] sel,
                                                input logic wake);
    crc_reader_t r;
    r = CRC_READER_OFF;
    if (wake) begin
      case (sel)
        `CRC_SEL_PORT1: begin
          r = CRC_READER_P1; // RQ2
        end
        `CRC_SEL_PORT2: begin
          r = CRC_READER_P2; // RQ2
        end
        default: begin
          r = CRC_READER_OFF; // RQ2
        end
      endcase
    end
    return r;
  endfunction : reader_decode

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] mode_switch_wake;
  logic [7:0] cfg_bus_width_irq;
  logic [7:0] cfg_clock_input;
  logic [7:0] next_mode_switch_wake;
  logic [7:0] next_cfg_bus_width_irq;
  logic [7:0] next_cfg_clock_input;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  // reserved bits are stored as written so a read-back matches the write
  always_comb begin
    next_mode_switch_wake = mode_switch_wake;
    next_cfg_bus_width_irq = cfg_bus_width_irq;
    next_cfg_clock_input = cfg_clock_input;
    next_rdata = rdata;
    next_rvalid = reg_req.rd;
    if (reg_req.wr) begin
      case (reg_index(reg_req.addr))
        IDX_MODE: begin
          next_mode_switch_wake = reg_req.wdata; // RQ1
        end
        IDX_BUS_IRQ: begin
          next_cfg_bus_width_irq = reg_req.wdata;
        end
        IDX_CLOCK: begin
          next_cfg_clock_input = reg_req.wdata;
        end
        default: begin
          next_rdata = rdata;
        end
      endcase
    end
    if (reg_req.rd) begin
      case (reg_index(reg_req.addr))
        IDX_MODE: begin
          next_rdata = mode_switch_wake;
        end
        IDX_BUS_IRQ: begin
          next_rdata = cfg_bus_width_irq;
        end
        IDX_CLOCK: begin
          next_rdata = cfg_clock_input;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_switch_wake <= `CRC_RST_MODE_SWITCH_WAKE; // RQ1
      cfg_bus_width_irq <= `CRC_RST_CFG_BUS_WIDTH_IRQ; // RQ15
      cfg_clock_input <= `CRC_RST_CFG_CLOCK_INPUT; // RQ9
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      mode_switch_wake <= next_mode_switch_wake;
      cfg_bus_width_irq <= next_cfg_bus_width_irq;
      cfg_clock_input <= next_cfg_clock_input;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata = rdata;
  assign reg_rvalid = rvalid;

  // ----------------------------------------------------------------
  // switches and wake
  // ----------------------------------------------------------------
  logic wake;
  logic [1:0] reader_sel;

  assign wake = mode_switch_wake[`CRC_BIT_MCU_WAKE_REQUEST]; // RQ3
  assign reader_sel =
    mode_switch_wake[`CRC_MSB_READER_SELECT:`CRC_LSB_READER_SELECT];
  assign port1_switch_close =
    mode_switch_wake[`CRC_BIT_PORT1_SWITCH_CLOSE]; // RQ1
  assign port2_switch_close =
    mode_switch_wake[`CRC_BIT_PORT2_SWITCH_CLOSE]; // RQ17
  assign mcu_wake_request = wake; // RQ3

  // ----------------------------------------------------------------
  // reader mode sequencing
  // ----------------------------------------------------------------
  crc_state_t state;
  crc_state_t next_state;
  crc_reader_t active;
  crc_reader_t next_active;
  crc_reader_cfg_t applied;
  crc_reader_cfg_t next_applied;
  crc_reader_t wanted;
  crc_reader_cfg_t live_cfg;

  assign wanted = reader_decode(reader_sel, wake);
  assign live_cfg.port2_narrow_bus =
    cfg_bus_width_irq[`CRC_BIT_PORT2_NARROW_BUS]; // RQ4
  assign live_cfg.port1_narrow_bus =
    cfg_bus_width_irq[`CRC_BIT_PORT1_NARROW_BUS]; // RQ5
  assign live_cfg.clk = clk_decode(
    cfg_clock_input[`CRC_MSB_CLOCK_INPUT_SELECT:`CRC_LSB_CLOCK_INPUT_SELECT]);

  // config is sampled once on entry; edits while running wait for re-entry
  always_comb begin
    next_state = state;
    next_active = active;
    next_applied = applied;
    case (state)
      CRC_ST_IDLE: begin
        if (wanted != CRC_READER_OFF) begin
          next_state = CRC_ST_RUN;
          next_active = wanted;
          next_applied = live_cfg; // RQ16
        end
      end
      CRC_ST_RUN: begin
        // a port change leaves reader mode first, then re-enters fresh
        if (wanted != active) begin
          next_state = CRC_ST_IDLE;
          next_active = CRC_READER_OFF;
        end
      end
      default: begin
        next_state = CRC_ST_IDLE;
        next_active = CRC_READER_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CRC_ST_IDLE;
      active <= CRC_READER_OFF;
      applied <= '0;
    end else begin
      state <= next_state;
      active <= next_active;
      applied <= next_applied;
    end
  end

  assign reader_port = active;
  assign reader_cfg = applied;
  assign reader_running = (state == CRC_ST_RUN);

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  crc_irq_gen #(
    .PULSE_CYCLES(IRQ_PULSE_CYCLES)
  ) u_irq (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .enable(wake), // RQ8
    .pulse_style(cfg_bus_width_irq[`CRC_BIT_IRQ_PULSE_STYLE]), // RQ7
    .polarity_high(cfg_bus_width_irq[`CRC_BIT_IRQ_POLARITY_HIGH]), // RQ8
    .irq_event(irq_event),
    .status_read(status_read),
    .irq_pin(irq_pin),
    .irq_active()
  );

endmodule : crc_regs

// ===== include/crc_consts.svh
// register offsets, field positions, reset values and timing for the bank
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CRC_OFF_MODE_SWITCH_WAKE 8'h00
`define CRC_OFF_CFG_BUS_WIDTH_IRQ 8'h01
`define CRC_OFF_CFG_CLOCK_INPUT 8'h02

// ----------------------------------------------------------------
// mode_switch_wake fields
// ----------------------------------------------------------------
`define CRC_BIT_PORT2_SWITCH_CLOSE 4
`define CRC_BIT_PORT1_SWITCH_CLOSE 3
`define CRC_MSB_READER_SELECT 2
`define CRC_LSB_READER_SELECT 1
`define CRC_BIT_MCU_WAKE_REQUEST 0

// ----------------------------------------------------------------
// cfg_bus_width_irq fields
// ----------------------------------------------------------------
`define CRC_BIT_PORT2_NARROW_BUS 7
`define CRC_BIT_PORT1_NARROW_BUS 6
`define CRC_BIT_IRQ_PULSE_STYLE 5
`define CRC_BIT_IRQ_POLARITY_HIGH 4

// ----------------------------------------------------------------
// cfg_clock_input fields
// ----------------------------------------------------------------
`define CRC_MSB_CLOCK_INPUT_SELECT 6
`define CRC_LSB_CLOCK_INPUT_SELECT 2

// ----------------------------------------------------------------
// reader select and clock input codes
// ----------------------------------------------------------------
`define CRC_SEL_PORT1 2'h1
`define CRC_SEL_PORT2 2'h2
`define CRC_CLK_DEFAULT 5'h00
`define CRC_CLK_19M2_SQUARE 5'h01
`define CRC_CLK_19M2_SINE 5'h02
`define CRC_CLK_13M_SINE 5'h05
`define CRC_CLK_12M_SQUARE 5'h09
`define CRC_CLK_12M_SINE 5'h0A
`define CRC_CLK_26M_SQUARE 5'h0D
`define CRC_CLK_26M_SINE 5'h0E

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CRC_RST_MODE_SWITCH_WAKE 8'h18
`define CRC_RST_CFG_BUS_WIDTH_IRQ 8'h00
`define CRC_RST_CFG_CLOCK_INPUT 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CRC_CLK_PERIOD_NS 10
`define CRC_IRQ_PULSE_MS 10
`define CRC_IRQ_PULSE_CYCLES \
  ((`CRC_IRQ_PULSE_MS * 1000000) / `CRC_CLK_PERIOD_NS)

`endif

// ===== include/crc_pkg.sv
// types shared by the card reader configuration bank
package crc_pkg;

  // ----------------------------------------------------------------
  // register access from the serial front end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } crc_reg_req_t;

  // ----------------------------------------------------------------
  // reader and clock input selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRC_READER_OFF,
    CRC_READER_P1,
    CRC_READER_P2
  } crc_reader_t;

  typedef enum logic [2:0] {
    CRC_FREQ_DEFAULT,
    CRC_FREQ_19M2,
    CRC_FREQ_13M,
    CRC_FREQ_12M,
    CRC_FREQ_26M
  } crc_freq_t;

  typedef struct packed {
    crc_freq_t freq;
    logic sine;
  } crc_clk_cfg_t;

  typedef struct packed {
    logic port2_narrow_bus;
    logic port1_narrow_bus;
    crc_clk_cfg_t clk;
  } crc_reader_cfg_t;

  typedef enum logic [1:0] {
    CRC_ST_IDLE,
    CRC_ST_RUN
  } crc_state_t;

endpackage : crc_pkg

// ===== hw/crc_irq_gen.sv
// interrupt pin generator: latched or timed pulse, either polarity
`include "crc_consts.svh"

module crc_irq_gen #(
  parameter int unsigned PULSE_CYCLES = `CRC_IRQ_PULSE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire logic pulse_style,
  input wire logic polarity_high,
  // events
  input wire logic irq_event,
  input wire logic status_read,
  // pin
  output logic irq_pin,
  output logic irq_active
);
  import crc_pkg::*;

  localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);

  initial begin
    if (PULSE_CYCLES < 1) begin
      $error("crc_irq_gen: PULSE_CYCLES must be at least 1");
    end
  end

  logic latched;
  logic next_latched;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic pin;
  logic next_pin;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_latched = latched;
    next_count = count;
    if (!enable) begin
      next_latched = 1'b0;
      next_count = '0;
    end else if (!pulse_style) begin
      next_count = '0;
      // set wins over a read in the same cycle
      if (irq_event) begin
        next_latched = 1'b1; // RQ6
      end else if (status_read) begin
        next_latched = 1'b0; // RQ6
      end
    end else begin
      next_latched = 1'b0;
      // a new event restarts the pulse rather than stretching a queue
      if (irq_event) begin
        next_count = CW'(PULSE_CYCLES); // RQ7
      end else if (count != '0) begin
        next_count = count - CW'(1); // RQ7
      end
    end
    next_pin = ((next_latched || (next_count != '0)) ~^ polarity_high)
      || !enable && !polarity_high; // RQ8
    if (!enable) begin
      next_pin = !polarity_high;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched <= 1'b0;
      count <= '0;
      pin <= 1'b1;
    end else begin
      latched <= next_latched;
      count <= next_count;
      pin <= next_pin;
    end
  end

  assign irq_pin = pin;
  assign irq_active = latched || (count != '0);

endmodule : crc_irq_gen

// ===== bench/crc_regs_monitor.sv
// assertion checker for the card reader configuration bank
`include "crc_consts.svh"
module crc_regs_monitor #(
  parameter int unsigned IRQ_PULSE_CYCLES = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // inputs
  input crc_pkg::crc_reg_req_t reg_req,
  input wire logic irq_event,
  input wire logic status_read,
  // outputs
  input wire logic port1_switch_close,
  input wire logic port2_switch_close,
  input wire logic mcu_wake_request,
  input crc_pkg::crc_reader_t reader_port,
  input crc_pkg::crc_reader_cfg_t reader_cfg,
  input wire logic reader_running,
  input wire logic irq_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import crc_pkg::*;
  // ----
  // register shadow and pulse age
  // ----
  logic [7:0] sh0, sh1, sh2, next_sh0, next_sh1, next_sh2;
  int unsigned cnt, next_cnt;
  always_comb begin
    next_sh0 = sh0;
    next_sh1 = sh1;
    next_sh2 = sh2;
    next_cnt = cnt;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `CRC_OFF_MODE_SWITCH_WAKE: next_sh0 = reg_req.wdata;
        `CRC_OFF_CFG_BUS_WIDTH_IRQ: next_sh1 = reg_req.wdata;
        `CRC_OFF_CFG_CLOCK_INPUT: next_sh2 = reg_req.wdata;
        default: ;
      endcase
    end
    // saturates just past the window, so old events read as expired
    // events only count while awake in pulse style
    if (!mcu_wake_request || !sh1[5]) begin
      next_cnt = 0;
    end else if (irq_event) begin
      next_cnt = 1;
    end else if (cnt != 0 && cnt <= IRQ_PULSE_CYCLES) begin
      next_cnt = cnt + 1;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh0 <= `CRC_RST_MODE_SWITCH_WAKE;
      sh1 <= `CRC_RST_CFG_BUS_WIDTH_IRQ;
      sh2 <= `CRC_RST_CFG_CLOCK_INPUT;
      cnt <= 0;
    end else begin
      sh0 <= next_sh0;
      sh1 <= next_sh1;
      sh2 <= next_sh2;
      cnt <= next_cnt;
    end
  end
  function automatic crc_clk_cfg_t exp_clk(input logic [7:0] r);
    case (r[6:2])
      `CRC_CLK_19M2_SQUARE: return '{CRC_FREQ_19M2, 1'b0};
      `CRC_CLK_19M2_SINE: return '{CRC_FREQ_19M2, 1'b1};
      `CRC_CLK_13M_SINE: return '{CRC_FREQ_13M, 1'b1};
      `CRC_CLK_12M_SQUARE: return '{CRC_FREQ_12M, 1'b0};
      `CRC_CLK_12M_SINE: return '{CRC_FREQ_12M, 1'b1};
      `CRC_CLK_26M_SQUARE: return '{CRC_FREQ_26M, 1'b0};
      `CRC_CLK_26M_SINE: return '{CRC_FREQ_26M, 1'b1};
      default: return '{CRC_FREQ_DEFAULT, 1'b0};
    endcase
  endfunction : exp_clk
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_sel_ok;
    sh0[0] && sh0[2:1] inside {2'h1, 2'h2} && !reader_running;
  endsequence
  sequence s_awake;
    mcu_wake_request && $past(mcu_wake_request) && $stable(sh1);
  endsequence
  property p_sw1;
    port1_switch_close == sh0[3];
  endproperty
  property p_sw2;
    port2_switch_close == sh0[4];
  endproperty
  property p_wake;
    mcu_wake_request == sh0[0];
  endproperty
  property p_entry;
    s_sel_ok |=> reader_running && reader_port == 2'($past(sh0) >> 1);
  endproperty
  property p_exit;
    reader_running && (!sh0[0] || sh0[2:1] != reader_port)
      |=> !reader_running && reader_port == CRC_READER_OFF;
  endproperty
  property p_hold;
    reader_running && $past(reader_running) |-> $stable(reader_cfg);
  endproperty
  property p_width;
    $rose(reader_running) |-> {reader_cfg.port2_narrow_bus,
      reader_cfg.port1_narrow_bus} == 2'($past(sh1) >> 6);
  endproperty
  property p_clk;
    $rose(reader_running) |-> reader_cfg.clk == exp_clk($past(sh2));
  endproperty
  property p_latch;
    s_awake ##0 (!sh1[5] && !reg_req.wr) |=> (irq_pin == sh1[4]) ==
      ($past(irq_event) || (!$past(status_read) && $past(irq_pin) == sh1[4]));
  endproperty
  property p_pulse;
    s_awake ##0 sh1[5] |->
      (irq_pin == sh1[4]) == (cnt != 0 && cnt <= IRQ_PULSE_CYCLES);
  endproperty
  property p_pol;
    !mcu_wake_request && !$past(mcu_wake_request) && $stable(sh1)
      |-> irq_pin != sh1[4];
  endproperty
  a_sw1: assert property (p_sw1)
    else $error("port 1 switch level wrong");
  a_sw2: assert property (p_sw2)
    else $error("port 2 switch level wrong");
  a_wake: assert property (p_wake)
    else $error("wake request level wrong");
  a_entry: assert property (p_entry)
    else $error("reader did not start on the selected port");
  a_exit: assert property (p_exit)
    else $error("reader did not stop");
  a_hold: assert property (p_hold)
    else $error("reader settings moved while running");
  a_width: assert property (p_width)
    else $error("bus width captured wrong");
  a_clk: assert property (p_clk)
    else $error("clock input captured wrong");
  a_latch: assert property (p_latch)
    else $error("latched interrupt wrong");
  a_pulse: assert property (p_pulse)
    else $error("pulse interrupt wrong");
  a_pol: assert property (p_pol)
    else $error("interrupt not idle while asleep");
endmodule : crc_regs_monitor

// ===== bench/crc_host.sv
// host model driving the byte register port and status reads
module crc_host (
  // clock
  input wire logic ref_clk,
  // register port
  output crc_pkg::crc_reg_req_t reg_req,
  output logic status_read
);
  timeunit 1ns;
  timeprecision 1ns;
  import crc_pkg::*;
  initial begin
    reg_req = '0;
    status_read = 1'b0;
  end
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    // reserved bits are sent as zero, except bits 1:0 at offset 02 and any bits at unlisted offsets
    m = a == 8'h00 ? 8'h1F : a == 8'h01 ? 8'hF0 :
      a == 8'h02 ? 8'h7F : 8'hFF;
    @(posedge ref_clk);
    #1;
    reg_req = '{addr: a, wr: w, rd: !w, wdata: d & m};
    @(posedge ref_clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
  endtask : req
  task automatic sread;
    @(posedge ref_clk);
    #1;
    status_read = 1'b1;
    @(posedge ref_clk);
    #1;
    status_read = 1'b0;
  endtask : sread
endmodule : crc_host

// ===== bench/crc_regs_tb.sv
// self-checking bench for the card reader configuration bank
module crc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import crc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_event = 1'b0;
  crc_reg_req_t reg_req;
  logic status_read, reg_rvalid, port1_switch_close, port2_switch_close;
  logic mcu_wake_request, reader_running, irq_pin;
  logic [7:0] reg_rdata;
  crc_reader_t reader_port;
  crc_reader_cfg_t reader_cfg;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  crc_host host (.ref_clk, .reg_req, .status_read);
  crc_regs #(.IRQ_PULSE_CYCLES(5)) dut (.ref_clk, .sys_rst, .reg_req,
    .reg_rdata, .reg_rvalid, .irq_event, .status_read, .port1_switch_close,
    .port2_switch_close, .mcu_wake_request, .reader_port, .reader_cfg,
    .reader_running, .irq_pin);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.req(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.req(1'b0, a, 8'h00);
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  task automatic ev;
    @(posedge ref_clk);
    #1;
    irq_event = 1'b1;
    @(posedge ref_clk);
    #1;
    irq_event = 1'b0;
  endtask : ev
  // bounded wait; running out ends the run
  task automatic wait_run(input logic e);
    for (int i = 0; i < 8 && reader_running !== e; i++) wait_cyc(1);
    if (reader_running !== e) begin
      error_cnt++;
      $display("Error at %0t: reader state wait ran out", $time);
      print_verdict();
    end
  endtask : wait_run
  // read answers are matched against the oldest note, mid-cycle
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      chk(reg_rdata, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] r;
    void'($urandom(57));
    wait_cyc(20);
    sys_rst = 1'b0;
    rd(8'h00, 8'h18);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    wr(8'h00, 8'h00);
    chk({port2_switch_close, port1_switch_close}, 8'h00);
    wr(8'h00, 8'h08);
    chk({port2_switch_close, port1_switch_close}, 8'h01);
    $display("reset and switch test done");
    for (int c = 0; c < 32; c++) begin
      r = $urandom();
      wr(8'h02, {1'b0, 5'(c), 2'h0});
      wr(8'h01, {r[1:0], 6'h00});
      wr(8'h00, c[0] ? 8'h1D : 8'h1B);
      chk(mcu_wake_request, 8'h01);
      wait_run(1'b1);
      chk(reader_port, c[0] ? 8'h02 : 8'h01);
      wr(8'h01, {~r[1:0], 6'h00});
      chk({reader_cfg.port2_narrow_bus, reader_cfg.port1_narrow_bus},
        r[1:0]);
      wr(8'h00, c[1] ? 8'h1F : 8'h1A);
      wait_run(1'b0);
      chk(reader_port, 8'h00);
    end
    $display("reader entry test done");
    wr(8'h00, 8'h19);
    for (int p = 0; p < 2; p++) begin
      wr(8'h01, p[0] ? 8'h10 : 8'h00);
      wait_cyc(2);
      chk(irq_pin, !p[0]);
      ev();
      wait_cyc(4);
      chk(irq_pin, p[0]);
      host.sread();
      wait_cyc(2);
      chk(irq_pin, !p[0]);
    end
    wr(8'h01, 8'h30);
    ev();
    wait_cyc(2);
    chk(irq_pin, 8'h01);
    wait_cyc(5);
    chk(irq_pin, 8'h00);
    ev();
    wait_cyc(3);
    ev();
    wait_cyc(3);
    chk(irq_pin, 8'h01);
    wait_cyc(5);
    chk(irq_pin, 8'h00);
    wr(8'h00, 8'h18);
    ev();
    wait_cyc(3);
    chk(irq_pin, 8'h00);
    $display("interrupt test done");
    sys_rst = 1'b1;
    wait_cyc(3);
    sys_rst = 1'b0;
    rd(8'h00, 8'h18);
    rd(8'h01, 8'h00);
    chk(irq_pin, 8'h01);
    wait_cyc(4);
    chk(8'(exp_q.size()), 8'h00);
    $display("second reset test done");
    print_verdict();
  end
endmodule : crc_regs_tb

bind crc_regs crc_regs_monitor #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) mon (
  .ref_clk, .sys_rst, .reg_req, .irq_event, .status_read,
  .port1_switch_close, .port2_switch_close, .mcu_wake_request,
  .reader_port, .reader_cfg, .reader_running, .irq_pin);
